// file: core/exc_dispatch.sv
// The address map and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ps
module exc_dispatch
    import exc_dispatch_pkg::*;
(
    input  wire logic        REF_CLK,
    input  wire logic        RST,
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic             HREADYOUT,
    output logic             HRESP,
    output logic [31:0]      HRDATA,
    input  wire pipe_ev_t    PIPE_EV,
    input  wire ipi_t        IPI_IN,
    input  wire logic        LOCAL_IRQ_PIN_A,
    input  wire logic        LOCAL_IRQ_PIN_B,
    input  wire logic        LOWPRI_REQ,
    output exc_t             EXC,
    output logic             SHUTDOWN,
    output ipi_t             IPI_OUT,
    output logic             INIT_PULSE,
    output logic             SMI_PULSE,
    output logic             STARTUP_PULSE,
    output logic             ARB_JOIN
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic div_ovf(logic word, logic zero,
                                     logic [17:0] q);
        logic signed [17:0] s;
        s = q;
        if (zero)
            return 1'b1;
        if (word)
            return (s > 18'sd32767) || (s < -18'sd32768);
        return (s > 18'sd127) || (s < -18'sd128);
    endfunction

    function automatic logic beyond(logic [7:0] v, logic [15:0] lim);
        return {5'h00, v, 3'h7} > lim;
    endfunction

    // ----------------------------------------------------------------
    // Bus slave
    // ----------------------------------------------------------------
    logic [CTRL_WIDTH-1:0] ctrl_r;
    logic [15:0]           vt_limit_r;
    logic [5:0]            simd_cause_r;
    logic [5:0]            simd_mask_r;
    logic [7:0]            lvt_vec_r;
    logic [1:0]            lvt_mask_r;
    logic [7:0]            log_dest_r;
    logic [3:0]            lic_id_r;
    logic                  nmi_block_r;
    logic                  nmi_pend_r;
    logic                  ipi_pend_r;
    logic [7:0]            ipi_vec_r;
    logic [7:0]            last_vec_r;
    logic                  shutdown_r;
    logic                  wr_pend_r;
    logic [7:0]            wr_addr_r;
    logic                  gp_pend_r;

    logic addr_ok;
    logic wr_now;
    logic bad_ctrl_wr;
    logic gp_sel;

    assign HREADYOUT = 1'b1;
    assign HRESP     = 1'b0;
    assign addr_ok   = HSEL && HREADY && HTRANS[1];
    assign wr_now    = wr_pend_r;
    assign bad_ctrl_wr = wr_now && wr_addr_r == OFF_CTRL &&
                         |HWDATA[31:CTRL_WIDTH];

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
        end else begin
            wr_pend_r <= addr_ok && HWRITE;
            wr_addr_r <= HADDR[7:0];
        end
    end

    // Read data is sampled in the address phase; no wait states needed
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            HRDATA <= 32'h0000_0000;
        end else if (addr_ok && !HWRITE) begin
            case (HADDR[7:0])
                OFF_CTRL:     HRDATA <= {27'h0, ctrl_r};
                OFF_VT_LIMIT: HRDATA <= {16'h0, vt_limit_r};
                OFF_SIMD_CS:  HRDATA <= {20'h0, simd_mask_r, simd_cause_r};
                OFF_LVT:      HRDATA <= {14'h0, lvt_mask_r, 8'h0, lvt_vec_r};
                OFF_LOG_DEST: HRDATA <= {24'h0, log_dest_r};
                OFF_LIC_ID:   HRDATA <= {28'h0, lic_id_r};
                OFF_STATUS:   HRDATA <= {20'h0, shutdown_r, nmi_block_r,
                                         nmi_pend_r, ipi_pend_r, last_vec_r};
                default:      HRDATA <= 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            ctrl_r    <= CTRL_RESET;
            gp_pend_r <= 1'b0;
        end else begin
            if (bad_ctrl_wr)
                gp_pend_r <= 1'b1;
            else if (wr_now && wr_addr_r == OFF_CTRL)
                ctrl_r <= HWDATA[CTRL_WIDTH-1:0];
            if (gp_sel && !bad_ctrl_wr)
                gp_pend_r <= 1'b0;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            vt_limit_r <= VT_LIMIT_RESET;
            log_dest_r <= 8'h00;
            lic_id_r   <= 4'h0;
            lvt_vec_r  <= 8'h00;
        end else if (wr_now) begin
            if (wr_addr_r == OFF_VT_LIMIT)
                vt_limit_r <= HWDATA[15:0];
            if (wr_addr_r == OFF_LOG_DEST)
                log_dest_r <= HWDATA[7:0];
            if (wr_addr_r == OFF_LIC_ID)
                lic_id_r <= HWDATA[3:0];
            if (wr_addr_r == OFF_LVT)
                lvt_vec_r <= HWDATA[7:0];
        end
    end

    // Masks stay forced while disabled; other contents are kept
    always_ff @(posedge REF_CLK) begin
        if (RST)
            lvt_mask_r <= 2'b11;
        else if (!ctrl_r[CTRL_LIC_EN])
            lvt_mask_r <= 2'b11;
        else if (wr_now && wr_addr_r == OFF_LVT)
            lvt_mask_r <= HWDATA[LVT_MASK_LSB+1:LVT_MASK_LSB];
    end

    // Cause bits: hardware set wins over a write-one clear
    logic [5:0] simd_unmasked;
    logic [5:0] simd_clr;
    assign simd_unmasked = PIPE_EV.simd_flags & ~simd_mask_r;
    assign simd_clr = (wr_now && wr_addr_r == OFF_SIMD_CS) ?
                      HWDATA[5:0] : 6'h00;

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            simd_cause_r <= 6'h00;
            simd_mask_r  <= SIMD_MASK_RESET;
        end else begin
            simd_cause_r <= (simd_cause_r & ~simd_clr) |
                            PIPE_EV.simd_flags;
            if (wr_now && wr_addr_r == OFF_SIMD_CS)
                simd_mask_r <= HWDATA[SIMD_MASK_LSB+5:SIMD_MASK_LSB];
        end
    end

    // ----------------------------------------------------------------
    // Local interrupt pins
    // ----------------------------------------------------------------
    logic [1:0] pin_s1_r;
    logic [1:0] pin_s2_r;
    logic       pin_b_prev_r;
    logic       pin_a_act;
    logic       pin_b_act;

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            pin_s1_r     <= 2'b00;
            pin_s2_r     <= 2'b00;
            pin_b_prev_r <= 1'b0;
        end else begin
            pin_s1_r     <= {LOCAL_IRQ_PIN_B, LOCAL_IRQ_PIN_A};
            pin_s2_r     <= pin_s1_r;
            pin_b_prev_r <= pin_b_act;
        end
    end

    assign pin_a_act = pin_s2_r[0] ^ ctrl_r[CTRL_POL_A];
    assign pin_b_act = pin_s2_r[1] ^ ctrl_r[CTRL_POL_B];

    // ----------------------------------------------------------------
    // Incoming IPIs
    // ----------------------------------------------------------------
    logic ipi_ok;
    logic ipi_nmi;
    logic nmi_edge;

    always_comb begin
        case (IPI_IN.kind)
            IPI_INIT, IPI_SMI, IPI_NMI, IPI_STARTUP,
            IPI_INIT_DEA: ipi_ok = IPI_IN.valid;
            default:      ipi_ok = IPI_IN.valid &&
                                   ctrl_r[CTRL_LIC_EN];
        endcase
    end

    // Level bit is ignored here: NMI and INIT act once per message
    assign ipi_nmi  = ipi_ok && IPI_IN.kind == IPI_NMI;
    assign nmi_edge = (pin_b_act && !pin_b_prev_r && !lvt_mask_r[1]) ||
                      ipi_nmi;

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            INIT_PULSE    <= 1'b0;
            SMI_PULSE     <= 1'b0;
            STARTUP_PULSE <= 1'b0;
        end else begin
            INIT_PULSE    <= ipi_ok && IPI_IN.kind == IPI_INIT;
            SMI_PULSE     <= ipi_ok && IPI_IN.kind == IPI_SMI;
            STARTUP_PULSE <= ipi_ok && IPI_IN.kind == IPI_STARTUP;
        end
    end

    assign ARB_JOIN = LOWPRI_REQ && ctrl_r[CTRL_LIC_EN] &&
                      !ipi_pend_r;

    // ----------------------------------------------------------------
    // Event selection
    // ----------------------------------------------------------------
    logic       take_nmi;
    logic       take_ipi;
    logic       take_pin;
    logic       sel_valid;
    logic [7:0] sel_vec;
    logic       sel_fault;
    logic       at_bnd;

    assign at_bnd   = PIPE_EV.boundary && !shutdown_r;
    assign take_nmi = at_bnd && nmi_pend_r && !nmi_block_r;
    assign take_ipi = at_bnd && PIPE_EV.int_en && ipi_pend_r;
    assign take_pin = at_bnd && PIPE_EV.int_en && pin_a_act &&
                      !lvt_mask_r[0];

    always_comb begin
        sel_valid = 1'b1;
        sel_vec   = 8'h00;
        sel_fault = 1'b1;
        gp_sel    = 1'b0;
        // Fixed order inside each category
        if (shutdown_r)
            sel_valid = 1'b0;
        else if (PIPE_EV.trap) begin
            sel_vec   = PIPE_EV.trap_vec;
            sel_fault = 1'b0;
        end else if (take_nmi || take_ipi || take_pin) begin
            sel_fault = 1'b0;
            if (take_nmi)
                sel_vec = VEC_NMI;
            else if (take_ipi)
                sel_vec = ipi_vec_r;
            else
                sel_vec = lvt_vec_r;
        end else if (PIPE_EV.fetch_pf)
            sel_vec = VEC_XLATE;
        else if (PIPE_EV.insn_len > MAX_INSN_LEN)
            sel_vec = VEC_PROTECT;
        else if (PIPE_EV.lock_bad)
            sel_vec = VEC_BAD_OP;
        else if (PIPE_EV.test_mov)
            sel_vec = VEC_BAD_OP;
        else if (PIPE_EV.hw_err && ctrl_r[CTRL_HW_ERR_EN])
            sel_vec = VEC_HW_ERROR;
        else if (gp_pend_r) begin
            sel_vec = VEC_PROTECT;
            gp_sel  = 1'b1;
        end else if (PIPE_EV.div_req &&
                     div_ovf(PIPE_EV.div_word, PIPE_EV.div_zero,
                             PIPE_EV.quot))
            sel_vec = VEC_DIVIDE;
        else if (PIPE_EV.pte_rsvd)
            sel_vec = VEC_XLATE;
        else if (PIPE_EV.mem_req && ctrl_r[CTRL_ALIGN_EN] &&
                 |(PIPE_EV.addr_lo &
                   ((3'h1 << PIPE_EV.mem_size) - 3'h1)))
            sel_vec = VEC_MISALIGN;
        else if (|simd_unmasked)
            sel_vec = VEC_SIMD;
        else
            sel_valid = 1'b0;
    end

    // ----------------------------------------------------------------
    // Dispatch and escalation
    // ----------------------------------------------------------------
    logic go_df;
    logic go_shut;
    assign go_df   = sel_valid && beyond(sel_vec, vt_limit_r);
    assign go_shut = go_df && beyond(VEC_DOUBLE, vt_limit_r);

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            EXC        <= '0;
            shutdown_r <= 1'b0;
            last_vec_r <= 8'h00;
        end else begin
            EXC.valid <= sel_valid && !go_shut;
            if (go_shut)
                shutdown_r <= 1'b1;
            if (sel_valid && !go_shut) begin
                EXC.vector    <= go_df ? VEC_DOUBLE : sel_vec;
                EXC.ret_fault <= go_df ? 1'b1 : sel_fault;
                last_vec_r    <= go_df ? VEC_DOUBLE : sel_vec;
            end
        end
    end

    assign SHUTDOWN = shutdown_r;

    // Set wins over clear for every pending flag
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            nmi_pend_r  <= 1'b0;
            nmi_block_r <= 1'b0;
        end else begin
            if (nmi_edge)
                nmi_pend_r <= 1'b1;
            else if (take_nmi && !PIPE_EV.trap)
                nmi_pend_r <= 1'b0;
            if (take_nmi && !PIPE_EV.trap)
                nmi_block_r <= 1'b1;
            else if (PIPE_EV.interrupt_return_done)
                nmi_block_r <= 1'b0;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            ipi_pend_r <= 1'b0;
            ipi_vec_r  <= 8'h00;
        end else if (ipi_ok && (IPI_IN.kind == IPI_FIXED ||
                                IPI_IN.kind == IPI_LOWPRI)) begin
            ipi_pend_r <= 1'b1;
            ipi_vec_r  <= IPI_IN.vector;
        end else if (take_ipi && !take_nmi && !PIPE_EV.trap)
            ipi_pend_r <= 1'b0;
    end

    // ----------------------------------------------------------------
    // Outgoing IPIs
    // ----------------------------------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (RST)
            IPI_OUT <= '0;
        else begin
            IPI_OUT.valid <= wr_now && wr_addr_r == OFF_ICR;
            if (wr_now && wr_addr_r == OFF_ICR) begin
                IPI_OUT.kind   <= HWDATA[10:8];
                IPI_OUT.vector <= HWDATA[7:0];
                IPI_OUT.level  <= (HWDATA[10:8] == IPI_INIT_DEA) &&
                                  HWDATA[15];
            end
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);

    property p_hw_err_en;
        EXC.valid && EXC.vector == VEC_HW_ERROR |->
            $past(ctrl_r[CTRL_HW_ERR_EN]) || $past(go_df);
    endproperty
    a_hw_err_en: assert property (p_hw_err_en)
        else $error("abort raised while disabled");

    property p_rsvd_wr;
        bad_ctrl_wr |=> ctrl_r == $past(ctrl_r) && gp_pend_r;
    endproperty
    a_rsvd_wr: assert property (p_rsvd_wr)
        else $error("reserved write changed control");

    property p_nmi_block;
        nmi_block_r |=> !(EXC.valid && EXC.vector == VEC_NMI);
    endproperty
    a_nmi_block: assert property (p_nmi_block)
        else $error("nmi taken while blocked");

    property p_shut;
        SHUTDOWN |=> SHUTDOWN && !EXC.valid;
    endproperty
    a_shut: assert property (p_shut)
        else $error("activity after shutdown");

    property p_lvt_mask;
        !ctrl_r[CTRL_LIC_EN] |=> lvt_mask_r == 2'b11;
    endproperty
    a_lvt_mask: assert property (p_lvt_mask)
        else $error("lvt mask open while disabled");

    property p_ipi_refuse;
        IPI_IN.valid && IPI_IN.kind == IPI_FIXED &&
            !ctrl_r[CTRL_LIC_EN] && !ipi_pend_r |=> !ipi_pend_r;
    endproperty
    a_ipi_refuse: assert property (p_ipi_refuse)
        else $error("ipi accepted while disabled");

    property p_icr_edge;
        IPI_OUT.valid && IPI_OUT.kind != IPI_INIT_DEA |-> !IPI_OUT.level;
    endproperty
    a_icr_edge: assert property (p_icr_edge)
        else $error("command ipi sent as level");

    property p_arb;
        ARB_JOIN |-> !ipi_pend_r;
    endproperty
    a_arb: assert property (p_arb)
        else $error("busy controller joined arbitration");

    property p_ext_bnd;
        take_pin && !PIPE_EV.trap && !take_nmi && !take_ipi |=>
            EXC.valid && (EXC.vector == $past(lvt_vec_r) ||
                          EXC.vector == VEC_DOUBLE) || SHUTDOWN;
    endproperty
    a_ext_bnd: assert property (p_ext_bnd)
        else $error("pin interrupt not dispatched");

    c_shut: cover property (SHUTDOWN);
    c_df:   cover property (EXC.valid && EXC.vector == VEC_DOUBLE);
    c_nmi:  cover property (EXC.valid && EXC.vector == VEC_NMI);
    c_ipi:  cover property (IPI_OUT.valid);

endmodule

// file: core/exc_dispatch_pkg.sv
package exc_dispatch_pkg;

    // ----------------------------------------------------------------
    // Vectors
    // ----------------------------------------------------------------
    localparam logic [7:0] VEC_DIVIDE    = 8'h00;
    localparam logic [7:0] VEC_NMI       = 8'h02;
    localparam logic [7:0] VEC_BAD_OP    = 8'h06;
    localparam logic [7:0] VEC_DOUBLE    = 8'h08;
    localparam logic [7:0] VEC_PROTECT   = 8'h0D;
    localparam logic [7:0] VEC_XLATE     = 8'h0E;
    localparam logic [7:0] VEC_MISALIGN  = 8'h11;
    localparam logic [7:0] VEC_HW_ERROR  = 8'h12;
    localparam logic [7:0] VEC_SIMD      = 8'h13;

    localparam logic [4:0] MAX_INSN_LEN  = 5'h0F;

    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL      = 8'h00;
    localparam logic [7:0] OFF_VT_LIMIT  = 8'h04;
    localparam logic [7:0] OFF_SIMD_CS   = 8'h08;
    localparam logic [7:0] OFF_LVT       = 8'h0C;
    localparam logic [7:0] OFF_LOG_DEST  = 8'h10;
    localparam logic [7:0] OFF_LIC_ID    = 8'h14;
    localparam logic [7:0] OFF_STATUS    = 8'h18;
    localparam logic [7:0] OFF_ICR       = 8'h1C;

    // Control register fields
    localparam int CTRL_HW_ERR_EN = 0;
    localparam int CTRL_ALIGN_EN  = 1;
    localparam int CTRL_LIC_EN    = 2;
    localparam int CTRL_POL_A     = 3;
    localparam int CTRL_POL_B     = 4;
    localparam int CTRL_WIDTH     = 5;
    localparam logic [4:0] CTRL_RESET = 5'h00;

    // SIMD control/status: causes [5:0], masks [11:6]
    localparam int SIMD_MASK_LSB = 6;
    localparam logic [5:0] SIMD_MASK_RESET = 6'h3F;

    // LOCAL_VECTOR_TABLE: pin a vector [7:0], pin a mask 16, pin b mask 17
    localparam int LVT_MASK_LSB = 16;
    localparam logic [15:0] VT_LIMIT_RESET = 16'h03FF;

    // INTERPROCESSOR_INTERRUPT kinds
    localparam logic [2:0] IPI_FIXED    = 3'h0;
    localparam logic [2:0] IPI_LOWPRI   = 3'h1;
    localparam logic [2:0] IPI_SMI      = 3'h2;
    localparam logic [2:0] IPI_INIT_DEA = 3'h3;
    localparam logic [2:0] IPI_NMI      = 3'h4;
    localparam logic [2:0] IPI_INIT     = 3'h5;
    localparam logic [2:0] IPI_STARTUP  = 3'h6;

    typedef struct packed {
        logic        boundary;
        logic        int_en;
        logic        trap;
        logic [7:0]  trap_vec;
        logic        fetch_pf;
        logic [4:0]  insn_len;
        logic        lock_bad;
        logic        test_mov;
        logic        div_req;
        logic        div_word;
        logic        div_zero;
        logic [17:0] quot;
        logic        pte_rsvd;
        logic        mem_req;
        logic [2:0]  addr_lo;
        logic [1:0]  mem_size;
        logic [5:0]  simd_flags;
        logic        hw_err;
        logic        interrupt_return_done;
    } pipe_ev_t;

    typedef struct packed {
        logic       valid;
        logic [2:0] kind;
        logic       level;
        logic [7:0] vector;
    } ipi_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] vector;
        logic       ret_fault;
    } exc_t;

endpackage

// file: verif/pipe_model.sv
`timescale 1ns/1ps
module pipe_model
    import exc_dispatch_pkg::*;
(
    input  wire logic REF_CLK,
    output pipe_ev_t  PIPE_EV
);
    // One event per call, then idle, so no bit lingers into the next cycle
    initial PIPE_EV = '0;
    task automatic issue(input pipe_ev_t e);
        @(posedge REF_CLK);
        PIPE_EV <= e;
        @(posedge REF_CLK);
        PIPE_EV <= '0;
    endtask
endmodule

// file: verif/tb.sv
`timescale 1ns/1ps
module tb
    import exc_dispatch_pkg::*;
;
    logic        clk = 0, rst = 1, hsel = 0, hwrite = 0, lowpri = 0;
    logic        pin_a = 0, pin_b = 0;
    logic [1:0]  htrans = '0;
    logic [31:0] haddr = '0, hwdata = '0, rd;
    logic [31:0] hrdata;
    logic        hready, hresp, shut, init_p, system_mgmt_interrupt, st, arb;
    logic [7:0]  last_vec;
    ipi_t        ipi_in = '0, ipi_out, last_ipi;
    exc_t        exc;
    pipe_ev_t    pe = '0, pipe_ev;
    int          error_cnt = 0, n_tests = 0;

    exc_dispatch u_exc_dispatch (.REF_CLK(clk), .RST(rst), .HSEL(hsel),
        .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
        .HWDATA(hwdata), .HREADY(hready), .HREADYOUT(hready), .HRESP(hresp),
        .HRDATA(hrdata), .PIPE_EV(pipe_ev), .IPI_IN(ipi_in),
        .LOCAL_IRQ_PIN_A(pin_a), .LOCAL_IRQ_PIN_B(pin_b), .LOWPRI_REQ(lowpri),
        .EXC(exc), .SHUTDOWN(shut), .IPI_OUT(ipi_out), .INIT_PULSE(init_p),
        .SMI_PULSE(system_mgmt_interrupt), .STARTUP_PULSE(st), .ARB_JOIN(arb));
    pipe_model u_pipe_model (.REF_CLK(clk), .PIPE_EV(pipe_ev));

    initial forever #25 clk = ~clk;
    // Pulses are too short to poll from tasks, so they are latched here
    always @(posedge clk) begin
        if (exc.valid === 1'b1) last_vec <= exc.vector;
        if (ipi_out.valid === 1'b1) last_ipi <= ipi_out;
    end

    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %s exp %0h got %0h", nm, e, g);
        end
    endtask
    task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {24'h0, a};
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic ev(logic [8:0] x);
        u_pipe_model.issue(pe);
        #1 chk("exc_valid", {31'h0, x[8]}, {31'h0, exc.valid});
        // Vector is held from the last dispatch, so only judged on one
        if (x[8])
            chk("exc_vec", {24'h0, x[7:0]}, {24'h0, exc.vector});
    endtask
    task automatic interprocessor_interrupt(logic [2:0] k);
        @(posedge clk);
        ipi_in <= {1'b1, k, 1'b0, 8'h55};
        @(posedge clk);
        ipi_in <= '0;
        #1;
    endtask

    task automatic t_exc;
        bus(0, OFF_CTRL, 0); chk("ctrl", 0, rd);
        pe = '0; pe.hw_err = 1; ev(0);
        pe = '0; pe.div_req = 1; pe.div_zero = 1; ev({1'b1, VEC_DIVIDE});
        chk("ret", 1, {31'h0, exc.ret_fault});
        pe.div_zero = 0; pe.quot = 18'h3FF80; ev(0);
        pe.div_word = 1; pe.quot = 18'h38000; ev(0);
        pe = '0; pe.lock_bad = 1; ev({1'b1, VEC_BAD_OP});
        pe = '0; pe.test_mov = 1; ev({1'b1, VEC_BAD_OP});
        pe = '0; pe.insn_len = 5'h0F; ev(0);
        pe.insn_len = 5'h10; ev({1'b1, VEC_PROTECT});
        pe = '0; pe.pte_rsvd = 1; ev({1'b1, VEC_XLATE});
        bus(1, OFF_CTRL, 32'h3); pe = '0; pe.hw_err = 1; ev({1'b1, VEC_HW_ERROR});
        pe = '0; pe.mem_req = 1; pe.addr_lo = 3'h1; pe.mem_size = 2'h1;
        ev({1'b1, VEC_MISALIGN});
        bus(1, OFF_SIMD_CS, 0); pe = '0; pe.simd_flags = 6'h01;
        ev({1'b1, VEC_SIMD});
        bus(0, OFF_SIMD_CS, 0); chk("cause", 32'h1, rd & 32'h1);
        last_vec = 8'hFF; bus(1, OFF_CTRL, 32'h23); repeat (3) @(posedge clk);
        chk("gp", {24'h0, VEC_PROTECT}, {24'h0, last_vec});
        bus(0, OFF_CTRL, 0); chk("ctrl", 32'h3, rd);
        pe = '0; pe.trap = 1; pe.trap_vec = 8'h03; pe.fetch_pf = 1;
        ev({1'b1, 8'h03});
        pe = '0; pe.fetch_pf = 1; pe.test_mov = 1; ev({1'b1, VEC_XLATE});
        $display("test exceptions done");
    endtask
    task automatic t_lic;
        bus(1, OFF_CTRL, 32'h4); bus(1, OFF_LVT, 0); bus(0, OFF_LVT, 0);
        chk("lvt", 0, rd & 32'h30000);
        lowpri <= 1'b1; @(posedge clk); #1 chk("join", 1, {31'h0, arb});
        bus(1, OFF_CTRL, 0); bus(0, OFF_LVT, 0);
        chk("lvt", 32'h30000, rd & 32'h30000);
        chk("join", 0, {31'h0, arb});
        bus(1, OFF_LOG_DEST, '1); bus(0, OFF_LOG_DEST, 0); chk("ldr", 32'hFF, rd);
        bus(1, OFF_LIC_ID, '1); bus(0, OFF_LIC_ID, 0); chk("id", 32'hF, rd);
        chk("resp", 0, {31'h0, hresp});
        interprocessor_interrupt(IPI_SMI); chk("smi", 1, {31'h0, system_mgmt_interrupt});
        interprocessor_interrupt(IPI_STARTUP); chk("sipi", 1, {31'h0, st});
        interprocessor_interrupt(IPI_INIT);
        chk("init", 1, {31'h0, init_p});
        interprocessor_interrupt(IPI_FIXED);
        bus(0, OFF_STATUS, 0);
        chk("pend", 0, rd & 32'h100);
        bus(1, OFF_ICR, 32'h8540); repeat (2) @(posedge clk);
        chk("icr", {28'h0, IPI_INIT, 1'b0}, {28'h0, last_ipi.kind, last_ipi.level});
        chk("icr_vec", 32'h40, {24'h0, last_ipi.vector});
        bus(1, OFF_ICR, 32'h8340); repeat (2) @(posedge clk);
        chk("icr", {28'h0, IPI_INIT_DEA, 1'b1}, {28'h0, last_ipi.kind, last_ipi.level});
        $display("test controller done");
    endtask
    task automatic t_irq;
        bus(1, OFF_CTRL, 32'h4);
        bus(1, OFF_LVT, 32'h41);
        interprocessor_interrupt(IPI_FIXED);
        chk("join", 0, {31'h0, arb});
        pe = '0;
        pe.boundary = 1;
        pe.int_en = 1;
        ev({1'b1, 8'h55});
        chk("join", 1, {31'h0, arb});
        @(posedge clk);
        pin_a <= 1'b1;
        repeat (3) @(posedge clk);
        pe = '0;
        ev(0);
        pe.boundary = 1;
        pe.int_en = 1;
        ev({1'b1, 8'h41});
        @(posedge clk);
        pin_a <= 1'b0;
        bus(1, OFF_CTRL, 32'hC);
        ev({1'b1, 8'h41});
        bus(1, OFF_CTRL, 32'h4);
        ev(0);
        pe = '0;
        pe.boundary = 1;
        interprocessor_interrupt(IPI_NMI);
        ev({1'b1, VEC_NMI});
        @(posedge clk);
        pin_b <= 1'b1;
        repeat (3) @(posedge clk);
        ev(0);
        pe = '0;
        pe.interrupt_return_done = 1;
        ev(0);
        pe = '0;
        pe.boundary = 1;
        ev({1'b1, VEC_NMI});
        @(posedge clk);
        pin_b <= 1'b0;
        $display("test interrupts done");
    endtask
    task automatic t_lim;
        bus(1, OFF_VT_LIMIT, 32'h67); pe = '0; pe.pte_rsvd = 1; ev({1'b1, VEC_DOUBLE});
        bus(1, OFF_VT_LIMIT, 32'h40); ev(0); @(posedge clk);
        #1 chk("shut", 1, {31'h0, shut});
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1 chk("shut", 0, {31'h0, shut});
        bus(0, OFF_VT_LIMIT, 0);
        chk("limit", {16'h0, VT_LIMIT_RESET}, rd);
        $display("test limit done");
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_exc;
        t_lic;
        t_irq;
        t_lim;
        close_out;
    end
    initial begin
        #200000;
        error_cnt++;
        close_out;
    end
endmodule
